// *** pkg/sbo_pkg.sv ***
// Constants and types for the SDRAM burst-order and mode-register block
package sbo_pkg;
  localparam logic [7:0] MA_BURST = 8'h01;
  localparam logic [7:0] MA_LATENCY = 8'h02;
  localparam logic [7:0] MA_DRIVE = 8'h03;
  localparam logic [7:0] MA_TEMP = 8'h04;
  localparam logic [2:0] BURST_LEN_4 = 3'h2;
  localparam logic [2:0] BURST_LEN_8 = 3'h3;
  localparam logic [2:0] BURST_LEN_16 = 3'h4;
  localparam int BURST_TYPE_BIT = 3;
  localparam int WRAP_CTRL_BIT = 4;
  localparam int TUF_BIT = 7;
  localparam int HOT_BIT = 2;
  localparam logic [7:0] BURST_RESET = 8'h22;
  localparam logic [3:0] LAT_RESET = 4'h1;
  localparam logic [3:0] RL_DEFAULT = 4'h3;
  localparam logic [3:0] WL_DEFAULT = 4'h1;
  localparam logic [3:0] DRIVE_RESET = 4'h2;
  localparam logic [2:0] RATE_RESET = 3'h3;
  localparam logic [2:0] RATE_RESERVED = 3'h4;
  localparam logic [2:0] RATE_DERATE = 3'h6;
  localparam logic [3:0] DRIVE_R5 = 4'h5;
  localparam logic [3:0] DRIVE_MAX = 4'h7;
  localparam logic [3:0] LAT_MAX = 4'h6;
  localparam int COL_W = 9;
  typedef enum logic [1:0] {SBO_IDLE, SBO_BURST} sbo_state_t;
endpackage

// *** rtl/sbo_latency_rom.sv ***
// Registered decode of the latency code into read and write latency
`timescale 1ns/100ps
module sbo_latency_rom (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Code in, latencies out
  input wire logic [3:0] code,
  output logic [3:0] read_latency,
  output logic [3:0] write_latency
);
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      read_latency <= sbo_pkg::RL_DEFAULT;
      write_latency <= sbo_pkg::WL_DEFAULT;
    end
    else
    begin
      case (code)
        4'h1:
        begin
          read_latency <= 4'h3;
          write_latency <= 4'h1;
        end
        4'h2:
        begin
          read_latency <= 4'h4;
          write_latency <= 4'h2;
        end
        4'h3:
        begin
          read_latency <= 4'h5;
          write_latency <= 4'h2;
        end
        4'h4:
        begin
          read_latency <= 4'h6;
          write_latency <= 4'h3;
        end
        4'h5:
        begin
          read_latency <= 4'h7;
          write_latency <= 4'h4;
        end
        4'h6:
        begin
          read_latency <= 4'h8;
          write_latency <= 4'h4;
        end
        default:
        begin
          read_latency <= read_latency;
          write_latency <= write_latency;
        end
      endcase
    end
  end
endmodule // sbo_latency_rom

// *** rtl/sbo_mode_regs.sv ***
// Mode registers and burst column sequencer of the SDRAM core
`timescale 1ns/100ps
module sbo_mode_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Mode register access
  input wire logic mr_write,
  input wire logic mr_read,
  input wire logic [7:0] mr_addr,
  input wire logic [7:0] mr_wdata,
  output logic [7:0] mr_rdata,
  output logic mr_rvalid,
  // Temperature sensor, asynchronous
  input wire logic [2:0] sensor_rate,
  // Burst start, column without its lowest bit
  input wire logic burst_start,
  input wire logic [7:0] start_col_hi,
  output logic [8:0] burst_col,
  output logic burst_valid,
  // Decoded settings
  output logic [3:0] read_latency,
  output logic [3:0] write_latency,
  output logic [3:0] drive_strength,
  output logic [2:0] burst_length,
  output logic burst_type,
  output logic wrap_control,
  output logic over_85c
);
  logic [7:0] burst_reg;
  logic [3:0] lat_code;
  logic [2:0] rate_s1;
  logic [2:0] rate_s2;
  logic [2:0] rate_seen;
  logic rate_take;
  logic [2:0] refresh_rate;
  logic temp_update_flag;
  logic [4:0] beats_left;
  logic [8:0] base_col;
  logic [3:0] wrap_mask;
  logic [8:0] next_col;
  sbo_pkg::sbo_state_t state;

  function automatic logic [3:0] len_mask(input logic [2:0] len);
    case (len)
      sbo_pkg::BURST_LEN_4: len_mask = 4'h3;
      sbo_pkg::BURST_LEN_8: len_mask = 4'h7;
      default: len_mask = 4'hF;
    endcase
  endfunction

  function automatic logic [4:0] len_beats(input logic [2:0] len);
    case (len)
      sbo_pkg::BURST_LEN_4: len_beats = 5'h04;
      sbo_pkg::BURST_LEN_8: len_beats = 5'h08;
      default: len_beats = 5'h10;
    endcase
  endfunction

  sbo_latency_rom u_lat (
    .core_clk(core_clk),
    .srst(srst),
    .code(lat_code),
    .read_latency(read_latency),
    .write_latency(write_latency)
  );

  // Configuration writes; read-only addresses fall through untouched
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      burst_reg <= sbo_pkg::BURST_RESET;
      lat_code <= sbo_pkg::LAT_RESET;
      drive_strength <= sbo_pkg::DRIVE_RESET;
    end
    else if (mr_write)
    begin
      case (mr_addr)
        sbo_pkg::MA_BURST:
          burst_reg <= mr_wdata;
        sbo_pkg::MA_LATENCY:
          if (mr_wdata[3:0] != 4'h0 && mr_wdata[3:0] <= sbo_pkg::LAT_MAX)
            lat_code <= mr_wdata[3:0];
        sbo_pkg::MA_DRIVE:
          if (mr_wdata[3:0] != 4'h0 && mr_wdata[3:0] != sbo_pkg::DRIVE_R5
              && mr_wdata[3:0] <= sbo_pkg::DRIVE_MAX)
            drive_strength <= mr_wdata[3:0];
        default:
          burst_reg <= burst_reg;
      endcase
    end
  end

  assign burst_length = burst_reg[2:0];
  assign burst_type = burst_reg[sbo_pkg::BURST_TYPE_BIT];
  assign wrap_control = burst_reg[sbo_pkg::WRAP_CTRL_BIT];

  // Sensor synchroniser
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rate_s1 <= sbo_pkg::RATE_RESET;
      rate_s2 <= sbo_pkg::RATE_RESET;
      rate_seen <= sbo_pkg::RATE_RESET;
    end
    else
    begin
      rate_s1 <= sensor_rate;
      rate_s2 <= rate_s1;
      rate_seen <= rate_s2;
    end
  end

  // Code is taken only after standing two cycles, so bit skew on the word never lands
  assign rate_take = rate_s2 == rate_seen && rate_s2 != sbo_pkg::RATE_RESERVED;

  // Refresh field holds last legal code; reserved code is not reported
  always_ff @(posedge core_clk)
  begin
    if (srst)
      refresh_rate <= sbo_pkg::RATE_RESET;
    else if (rate_take)
      refresh_rate <= rate_s2;
  end

  assign over_85c = refresh_rate[sbo_pkg::HOT_BIT];

  // Update flag: a change in the read cycle wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      temp_update_flag <= 1'b0;
    else if (rate_take && rate_s2 != refresh_rate)
      temp_update_flag <= 1'b1;
    else if (mr_read && mr_addr == sbo_pkg::MA_TEMP)
      temp_update_flag <= 1'b0;
  end

  // Read data; write-only registers read as zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mr_rdata <= 8'h00;
      mr_rvalid <= 1'b0;
    end
    else
    begin
      mr_rvalid <= mr_read;
      if (mr_read && mr_addr == sbo_pkg::MA_TEMP)
        mr_rdata <= {temp_update_flag, 4'h0, refresh_rate};
      else
        mr_rdata <= 8'h00;
    end
  end

  // Burst sequencer
  assign next_col = {base_col[8:4], (base_col[3:0] & ~wrap_mask)
    | ((burst_col[3:0] + 4'h1) & wrap_mask)};

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state <= sbo_pkg::SBO_IDLE;
      beats_left <= 5'h00;
      base_col <= 9'h000;
      burst_col <= 9'h000;
      wrap_mask <= 4'hF;
      burst_valid <= 1'b0;
    end
    else
    begin
      case (state)
        sbo_pkg::SBO_IDLE:
          if (burst_start)
          begin
            base_col <= {start_col_hi, 1'b0};
            burst_col <= {start_col_hi, 1'b0};
            // No-wrap bursts count straight through the column
            wrap_mask <= wrap_control ? 4'hF : len_mask(burst_length);
            beats_left <= len_beats(burst_length) - 5'h01;
            burst_valid <= 1'b1;
            state <= sbo_pkg::SBO_BURST;
          end
          else
            burst_valid <= 1'b0;
        sbo_pkg::SBO_BURST:
          if (beats_left == 5'h00)
          begin
            burst_valid <= 1'b0;
            state <= sbo_pkg::SBO_IDLE;
          end
          else
          begin
            burst_col <= wrap_mask == 4'hF && wrap_control
              ? burst_col + 9'h001 : next_col;
            beats_left <= beats_left - 5'h01;
          end
        default:
          state <= sbo_pkg::SBO_IDLE;
      endcase
    end
  end

  a_tuf_clear_read: assert property (@(posedge core_clk) disable iff (srst)
    mr_read && mr_addr == sbo_pkg::MA_TEMP && $stable(rate_s2)
      && rate_s2 == refresh_rate |=> !temp_update_flag)
    else $error("update flag not cleared by read");
  a_tuf_set_change: assert property (@(posedge core_clk) disable iff (srst)
    $changed(refresh_rate) |-> temp_update_flag)
    else $error("update flag missing after rate change");
  a_burst_wrap16: assert property (@(posedge core_clk) disable iff (srst)
    state == sbo_pkg::SBO_BURST && beats_left != 5'h00 && wrap_mask == 4'hF
      && !wrap_control |=> burst_col[3:0] == $past(burst_col[3:0]) + 4'h1
      && burst_col[8:4] == $past(burst_col[8:4]))
    else $error("16-beat wrap order broken");
  a_lsb_zero: assert property (@(posedge core_clk) disable iff (srst)
    state == sbo_pkg::SBO_IDLE && burst_start |=> burst_valid && burst_col[0] == 1'b0)
    else $error("column lsb not zero");
  a_burst_len: assert property (@(posedge core_clk) disable iff (srst)
    state == sbo_pkg::SBO_IDLE && burst_start && burst_length == sbo_pkg::BURST_LEN_4
      && !wrap_control |=> burst_valid [*4] ##1 !burst_valid)
    else $error("4-beat burst length wrong");
  a_hot_flag: assert property (@(posedge core_clk) disable iff (srst)
    over_85c == (refresh_rate >= 3'h4))
    else $error("hot indication wrong");
  a_no_reserved: assert property (@(posedge core_clk) disable iff (srst)
    refresh_rate != sbo_pkg::RATE_RESERVED)
    else $error("reserved rate reported");
  a_drive_legal: assert property (@(posedge core_clk) disable iff (srst)
    mr_write && mr_addr == sbo_pkg::MA_DRIVE && mr_wdata[3:0] == sbo_pkg::DRIVE_R5
      |=> $stable(drive_strength))
    else $error("reserved drive code taken");
  a_ro_write: assert property (@(posedge core_clk) disable iff (srst)
    mr_write && mr_addr == sbo_pkg::MA_TEMP |=> $stable(burst_reg)
      && $stable(lat_code) && $stable(drive_strength))
    else $error("read-only write changed state");
endmodule // sbo_mode_regs

// *** sim/sbo_host_model.sv ***
// Host controller model issuing mode-register and burst commands
`timescale 1ns/100ps
module sbo_host_model (
  // Clock
  input wire logic core_clk,
  // Mode register access
  output logic mr_write,
  output logic mr_read,
  output logic [7:0] mr_addr,
  output logic [7:0] mr_wdata,
  input wire logic [7:0] mr_rdata,
  input wire logic mr_rvalid,
  // Burst start
  output logic burst_start,
  output logic [7:0] start_col_hi
);
  logic derate = 1'b0;
  logic out_of_limit = 1'b0;
  initial
  begin
    mr_write = 1'b0;
    mr_read = 1'b0;
    mr_addr = 8'h00;
    mr_wdata = 8'h00;
    burst_start = 1'b0;
    start_col_hi = 8'h00;
  end
  task automatic mr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    mr_write <= 1'b1;
    mr_addr <= a;
    mr_wdata <= d;
    @(posedge core_clk);
    mr_write <= 1'b0;
  endtask
  // Temperature polls feed the refresh and timing policy
  task automatic mr_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge core_clk);
    mr_read <= 1'b1;
    mr_addr <= a;
    @(posedge core_clk);
    mr_read <= 1'b0;
    #1;
    for (n = 0; n < 4 && mr_rvalid !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    d = mr_rdata;
    if (a == 8'h04)
    begin
      derate = (d[2:0] == 3'h6);
      out_of_limit = (d[2:0] == 3'h0) || (d[2:0] == 3'h7);
    end
  endtask
  // No-wrap starts at column 000 or 1FE are never issued
  task automatic burst(input logic [7:0] hi, input logic nw);
    if (!nw || ({hi, 1'b0} > 9'h001 && {hi, 1'b0} < 9'h1FE))
    begin
      @(posedge core_clk);
      burst_start <= 1'b1;
      start_col_hi <= hi;
      @(posedge core_clk);
      burst_start <= 1'b0;
    end
  endtask
endmodule // sbo_host_model

// *** sim/testbench.sv ***
// Self-checking testbench for the mode registers and burst sequencer
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] sensor_rate = 3'h3;
  logic mr_write, mr_read, mr_rvalid, burst_start, burst_valid;
  logic [7:0] mr_addr, mr_wdata, mr_rdata, start_col_hi, rd;
  logic [8:0] burst_col;
  logic [3:0] read_latency, write_latency, drive_strength, lat, ds;
  logic [2:0] burst_length;
  logic burst_type, wrap_control, over_85c;
  logic [3:0] wl [0:7] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h0};
  int n_errors = 0;
  int num_checks = 0;
  int c;
  always #2 core_clk = ~core_clk;
  sbo_mode_regs i_dut (.core_clk(core_clk), .srst(srst), .mr_write(mr_write),
    .mr_read(mr_read), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .mr_rdata(mr_rdata),
    .mr_rvalid(mr_rvalid), .sensor_rate(sensor_rate), .burst_start(burst_start),
    .start_col_hi(start_col_hi), .burst_col(burst_col), .burst_valid(burst_valid),
    .read_latency(read_latency), .write_latency(write_latency),
    .drive_strength(drive_strength), .burst_length(burst_length),
    .burst_type(burst_type), .wrap_control(wrap_control), .over_85c(over_85c));
  sbo_host_model i_host (.core_clk(core_clk), .mr_write(mr_write), .mr_read(mr_read),
    .mr_addr(mr_addr), .mr_wdata(mr_wdata), .mr_rdata(mr_rdata), .mr_rvalid(mr_rvalid),
    .burst_start(burst_start), .start_col_hi(start_col_hi));
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host.mr_rd(a, rd);
    chk("mr_rvalid", 9'h001, 9'(mr_rvalid));
    chk("mr_rdata", 9'(exp), 9'(rd));
  endtask
  task automatic set_rate(input logic [2:0] r);
    @(posedge core_clk);
    sensor_rate <= r;
    tick(6);
  endtask
  // Programs the burst register, then follows every beat of one burst
  task automatic bcheck(input logic [7:0] mode, input logic [7:0] hi, input int len,
      input logic [8:0] mask);
    logic [8:0] st;
    int i;
    st = {hi, 1'b0};
    i_host.mr_wr(8'h01, mode);
    tick(2);
    chk("burst_length", 9'(mode[2:0]), 9'(burst_length));
    chk("burst_type", 9'(mode[3]), 9'(burst_type));
    chk("wrap_control", 9'(mode[4]), 9'(wrap_control));
    i_host.burst(hi, mode[4]);
    #1;
    for (i = 0; i < 4 && burst_valid !== 1'b1; i++)
      tick(1);
    for (i = 0; i < len; i++)
    begin
      chk("burst_col", (st & ~mask) | ((st + 9'(i)) & mask), burst_col);
      chk("burst_valid", 9'h001, 9'(burst_valid));
      tick(1);
    end
    chk("burst_idle", 9'h000, 9'(burst_valid));
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    chk("read_latency", 9'h003, 9'(read_latency));
    chk("write_latency", 9'h001, 9'(write_latency));
    chk("drive_strength", 9'h002, 9'(drive_strength));
    chk("burst_length", 9'h002, 9'(burst_length));
    rd_chk(8'h04, 8'h03);
    lat = 4'h1;
    ds = 4'h2;
    for (c = 0; c < 8; c++)
    begin
      i_host.mr_wr(8'h02, 8'(c));
      if (c >= 1 && c <= 6)
        lat = 4'(c);
      tick(3);
      chk("read_latency", 9'(lat) + 9'h002, 9'(read_latency));
      chk("write_latency", 9'(wl[lat]), 9'(write_latency));
      i_host.mr_wr(8'h03, 8'(c));
      if (c inside {1, 2, 3, 4, 6, 7})
        ds = 4'(c);
      tick(3);
      chk("drive_strength", 9'(ds), 9'(drive_strength));
    end
    set_rate(3'h6);
    rd_chk(8'h04, 8'h86);
    chk("over_85c", 9'h001, 9'(over_85c));
    chk("derate", 9'h001, 9'(i_host.derate));
    rd_chk(8'h04, 8'h06);
    set_rate(3'h4);
    rd_chk(8'h04, 8'h06);
    set_rate(3'h7);
    rd_chk(8'h04, 8'h87);
    chk("out_of_limit", 9'h001, 9'(i_host.out_of_limit));
    set_rate(3'h1);
    chk("over_85c", 9'h000, 9'(over_85c));
    rd_chk(8'h04, 8'h81);
    i_host.mr_wr(8'h04, 8'hFF);
    rd_chk(8'h04, 8'h01);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h20, 8'h00);
    bcheck(8'h04, 8'h03, 16, 9'h00F);
    bcheck(8'h04, 8'h0F, 16, 9'h00F);
    bcheck(8'h03, 8'h05, 8, 9'h007);
    bcheck(8'h02, 8'h03, 4, 9'h003);
    bcheck(8'h12, 8'h10, 4, 9'h1FF);
    bcheck(8'h12, 8'hFD, 4, 9'h1FF);
    complete_run;
  end
  // Whole run takes about 230 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run;
  end
endmodule // testbench
